// *** inc/processor_data_path_consts.svh ***
// constants for the processor data path
`ifndef PROCESSOR_DATA_PATH_CONSTS_SVH
`define PROCESSOR_DATA_PATH_CONSTS_SVH
// ----------------------------------------
// sizes
// ----------------------------------------
`define PDP_RF_DEPTH     64
`define PDP_RF_SLICE_W   18
`define PDP_WORD_W       32
`define PDP_MEM_DEPTH    16384
`define PDP_MEM_W        36
`define PDP_MEM_AW       14
`define PDP_RF_AW        6
`define PDP_SCAN_LEN     96
// ----------------------------------------
// reset values
// ----------------------------------------
`define PDP_ADDR_RST     14'h0000
`define PDP_OPCODE_RST   36'h000000000
`endif

// *** inc/processor_data_path_pkg.sv ***
// types for the processor data path
package processor_data_path_pkg;
  // unit operation codes
  typedef enum logic [3:0] {
    OP_ADD   = 4'h0,
    OP_SUB   = 4'h1,
    OP_SHL   = 4'h2,
    OP_SHR   = 4'h3,
    OP_MERGE = 4'h4,
    OP_MUL   = 4'h5,
    OP_DIV   = 4'h6,
    OP_FADD  = 4'h7,
    OP_FMUL  = 4'h8,
    OP_PASS  = 4'h9
  } unit_op_t;
  // source of the memory address
  typedef enum logic [1:0] {
    MADR_READ_A = 2'h0,
    MADR_CNT0   = 2'h1,
    MADR_CNT1   = 2'h2,
    MADR_HOST   = 2'h3
  } madr_sel_t;
  // diagnostic clock gating controller states
  typedef enum logic [1:0] {
    DG_RUN   = 2'h0,
    DG_HALT  = 2'h1,
    DG_STEP  = 2'h2
  } diag_state_t;
endpackage

// *** sim/host_dma_model.sv ***
// host side model: dma master on the shared memory
`timescale 1ns/100ps
module host_dma_model (
  // clock
  input  wire logic        clk_i,
  // dma port
  output logic             req_o,
  output logic             we_o,
  output logic [13:0]      addr_o,
  output logic [35:0]      wdata_o,
  input  wire logic        ack_i,
  input  wire logic [35:0] rdata_i
);
  // idle at time zero
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 14'h0000;
    wdata_o = 36'h000000000;
  end
  // one access, held until ack is sampled or four edges pass; lines then show the inverse, not stale values
  task automatic xfer(input logic w, input logic [13:0] a, input logic [35:0] d,
                      output logic [35:0] q, output logic ok);
    ok = 1'b0;
    q = 36'h000000000;
    req_o = 1'b1;
    we_o = w;
    addr_o = a;
    wdata_o = d;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_i);
      ok = ack_i;
      q = rdata_i;
    end
    #1;
    req_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    @(posedge clk_i);
    #1;
  endtask
endmodule // host_dma_model

// *** sim/pdp_monitor.sv ***
// assertion checker for the processor data path
`timescale 1ns/100ps
module pdp_monitor
  import processor_data_path_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  // watched ports
  input wire logic        fetch_i,
  input wire logic        cnt0_inc_i,
  input wire logic        cnt0_load_i,
  input wire madr_sel_t   madr_sel_i,
  input wire logic        host_req_i,
  input wire logic        host_ack_o,
  input wire logic [35:0] host_rdata_o,
  input wire logic        diag_halt_i,
  input wire logic        diag_step_i,
  input wire logic        clk_en_o,
  input wire logic [31:0] result_bus_o,
  input wire logic [35:0] opcode_o,
  input wire logic [13:0] mem_addr_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  // ----------------------------------------
  // host access
  // ----------------------------------------
  a_ack_cause: assert property (host_ack_o |-> $past(host_req_i) && !$past(clk_en_o))
    else $error("ack without a halted host request");
  a_refuse_run: assert property (clk_en_o && host_req_i |=> !host_ack_o)
    else $error("host served while running");
  a_rdata_hold: assert property (!$past(srst_i) && $changed(host_rdata_o) |-> host_ack_o)
    else $error("read data moved without ack");
  // ----------------------------------------
  // clock gating and state updates
  // ----------------------------------------
  a_halt_stops: assert property ((diag_halt_i && !diag_step_i)[*8] |-> !clk_en_o)
    else $error("running while halt held");
  a_result_frozen: assert property (!$past(srst_i) && !$past(clk_en_o) |-> $stable(result_bus_o))
    else $error("result bus moved while gated");
  a_opcode_fetch: assert property (!$past(srst_i) && $changed(opcode_o) |-> $past(fetch_i && clk_en_o))
    else $error("opcode moved without enabled fetch");
  a_addr_frozen: assert property (!$past(srst_i) && !$past(clk_en_o) && !$past(host_req_i)
    |-> $stable(mem_addr_o))
    else $error("memory address moved while gated");
  a_addr_count: assert property (clk_en_o && fetch_i && madr_sel_i == MADR_CNT0 && cnt0_inc_i && !cnt0_load_i
    ##1 clk_en_o && fetch_i && madr_sel_i == MADR_CNT0 |=> mem_addr_o == $past(mem_addr_o) + 14'h0001)
    else $error("address counter did not step");
endmodule // pdp_monitor
bind processor_data_path pdp_monitor mon (.sys_clk_i, .srst_i, .fetch_i, .cnt0_inc_i, .cnt0_load_i,
  .madr_sel_i, .host_req_i, .host_ack_o, .host_rdata_o, .diag_halt_i, .diag_step_i, .clk_en_o,
  .result_bus_o, .opcode_o, .mem_addr_o);

// *** sim/testbench.sv ***
// self-checking bench for the processor data path
`timescale 1ns/100ps
module testbench;
  import processor_data_path_pkg::*;
  logic        sys_clk_i, srst_i, wr_a_en_i, wr_b_en_i, mem_rd_i, mem_wr_i, fetch_i, fetch_to_rf_i;
  logic [5:0]  rd_a_addr_i, rd_b_addr_i, wr_a_addr_i, wr_b_addr_i;
  logic        cnt0_load_i, cnt1_load_i, cnt0_inc_i, cnt1_inc_i, host_req_i, host_we_i, host_ack_o;
  unit_op_t    op_i;
  madr_sel_t   madr_sel_i;
  logic [4:0]  shift_i;
  logic [31:0] merge_mask_i, result_bus_o;
  logic [13:0] host_addr_i, mem_addr_o;
  logic [35:0] host_wdata_i, host_rdata_o, opcode_o, q;
  logic        diag_halt_i, diag_step_i, diag_scan_en_i, diag_scan_in_i, diag_scan_out_o, clk_en_o, ok;
  int          fail_count, check_count;
  // ----------------------------------------
  // design and host model
  // ----------------------------------------
  processor_data_path uut (.sys_clk_i, .srst_i, .rd_a_addr_i, .rd_b_addr_i, .wr_a_addr_i, .wr_b_addr_i,
    .wr_a_en_i, .wr_b_en_i, .op_i, .shift_i, .merge_mask_i, .mem_rd_i, .mem_wr_i, .madr_sel_i,
    .cnt0_load_i, .cnt1_load_i, .cnt0_inc_i, .cnt1_inc_i, .fetch_i, .fetch_to_rf_i, .host_req_i,
    .host_we_i, .host_addr_i, .host_wdata_i, .host_rdata_o, .host_ack_o, .diag_halt_i, .diag_step_i,
    .diag_scan_en_i, .diag_scan_in_i, .diag_scan_out_o, .clk_en_o, .result_bus_o, .opcode_o, .mem_addr_o);
  host_dma_model host (.clk_i(sys_clk_i), .req_o(host_req_i), .we_o(host_we_i), .addr_o(host_addr_i),
    .wdata_o(host_wdata_i), .ack_i(host_ack_o), .rdata_i(host_rdata_o));
  // 40 ns clock
  always #20 sys_clk_i = ~sys_clk_i;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic cmp(input logic [35:0] g, input logic [35:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic idle();
    {wr_a_en_i, wr_b_en_i, mem_rd_i, mem_wr_i, fetch_i, fetch_to_rf_i} = 6'h00;
    {cnt0_load_i, cnt1_load_i, cnt0_inc_i, cnt1_inc_i} = 4'h0;
    madr_sel_i = MADR_READ_A;
  endtask
  task automatic uop(input unit_op_t o, input logic [5:0] ra, rb, wa, input logic we);
    op_i = o;
    rd_a_addr_i = ra;
    rd_b_addr_i = rb;
    wr_a_addr_i = wa;
    wr_a_en_i = we;
    tick();
  endtask
  task automatic wait_en(input logic v);
    for (int i = 0; i < 40; i++) begin
      if (clk_en_o === v)
        return;
      tick();
    end
    fail_count++;
    $display("BAD %0t run enable wait ran out", $time);
    report_and_stop();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_dma();
    host.xfer(1'b1, 14'h0000, 36'h00000000A, q, ok);
    cmp({35'h0, ok}, 36'h000000001);
    host.xfer(1'b1, 14'h0001, 36'hA12345678, q, ok);
    host.xfer(1'b1, 14'h3FFF, 36'hFFFFFFFFF, q, ok);
    host.xfer(1'b0, 14'h0001, 36'h000000000, q, ok);
    cmp(q, 36'hA12345678);
    host.xfer(1'b0, 14'h3FFF, 36'h000000000, q, ok);
    cmp(q, 36'hFFFFFFFFF);
  endtask
  task automatic t_fetch();
    diag_halt_i = 1'b0;
    wait_en(1'b1);
    host.xfer(1'b0, 14'h0001, 36'h000000000, q, ok);
    cmp({35'h0, ok}, 36'h000000000);
    {fetch_i, fetch_to_rf_i, cnt0_inc_i} = 3'h7;
    madr_sel_i = MADR_CNT0;
    wr_b_addr_i = 6'h01;
    tick();
    cmp(opcode_o, 36'h00000000A);
    cmp({22'h0, mem_addr_o}, 36'h000000000);
    wr_b_addr_i = 6'h02;
    tick();
    cmp({22'h0, mem_addr_o}, 36'h000000001);
    idle();
  endtask
  task automatic t_alu();
    unit_op_t    ops [10] = '{OP_ADD, OP_SUB, OP_SHL, OP_SHR, OP_MERGE, OP_MUL, OP_DIV,
                              OP_FADD, OP_FMUL, OP_PASS};
    logic [31:0] ev [10] = '{32'h12345682, 32'h1234566E, 32'h23456780, 32'h01234567,
                             32'h1234000A, 32'hB60B60B0, 32'h01D208A5,
                             32'h12345682, 32'hB60B60B0, 32'h12345678};
    shift_i = 5'h04;
    merge_mask_i = 32'hFFFF0000;
    for (int i = 0; i < 10; i++) begin
      uop(ops[i], 6'h02, 6'h01, 6'h03, 1'b0);
      cmp({4'h0, result_bus_o}, {4'h0, ev[i]});
    end
    uop(OP_ADD, 6'h02, 6'h01, 6'h03, 1'b1);
  endtask
  task automatic t_mem();
    mem_wr_i = 1'b1;
    uop(OP_ADD, 6'h01, 6'h03, 6'h00, 1'b0);
    cmp({22'h0, mem_addr_o}, 36'h00000000A);
    {mem_wr_i, mem_rd_i, wr_b_en_i} = 3'h3;
    wr_b_addr_i = 6'h04;
    uop(OP_ADD, 6'h01, 6'h02, 6'h05, 1'b1);
    cmp({4'h0, result_bus_o}, 36'h012345682);
    // two counted stores: rf[4] to word 2, rf[5] to word 3
    {mem_wr_i, mem_rd_i, wr_b_en_i, cnt0_inc_i} = 4'hD;
    madr_sel_i = MADR_CNT0;
    uop(OP_ADD, 6'h01, 6'h04, 6'h00, 1'b0);
    uop(OP_ADD, 6'h01, 6'h05, 6'h00, 1'b0);
    // second counter loads from read port A, then counts
    {mem_wr_i, cnt0_inc_i, cnt1_load_i} = 3'h1;
    tick();
    {cnt1_load_i, cnt1_inc_i} = 2'h1;
    madr_sel_i = MADR_CNT1;
    tick();
    cmp({22'h0, mem_addr_o}, 36'h00000000A);
    tick();
    cmp({22'h0, mem_addr_o}, 36'h00000000B);
    idle();
    diag_halt_i = 1'b1;
    wait_en(1'b0);
    for (int i = 0; i < 3; i++) begin
      host.xfer(1'b0, (i == 0) ? 14'h000A : 14'(i + 1), 36'h000000000, q, ok);
      cmp(q, 36'h012345682);
    end
  endtask
  task automatic t_step();
    logic [3:0] n;
    n = 4'h0;
    repeat (3) uop(OP_ADD, 6'h02, 6'h02, 6'h00, 1'b0);
    cmp({4'h0, result_bus_o}, 36'h01234568C);
    diag_step_i = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (i == 4)
        diag_step_i = 1'b0;
      n = n + {3'h0, clk_en_o};
      tick();
    end
    cmp({32'h0, n}, 36'h000000001);
    cmp({4'h0, result_bus_o}, 36'h02468ACF0);
  endtask
  // fill the scan chain with ones, then zeros, and watch them come out
  task automatic t_scan();
    diag_scan_en_i = 1'b1;
    for (int k = 1; k >= 0; k--) begin
      diag_scan_in_i = k[0];
      repeat (110) tick();
      cmp({35'h0, diag_scan_out_o}, 36'(k));
    end
    diag_scan_en_i = 1'b0;
    diag_scan_in_i = 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fail_count = 0;
    check_count = 0;
    sys_clk_i = 1'b0;
    srst_i = 1'b1;
    {diag_halt_i, diag_step_i, diag_scan_en_i, diag_scan_in_i} = 4'h8;
    {rd_a_addr_i, rd_b_addr_i, wr_a_addr_i, wr_b_addr_i} = 24'h000000;
    op_i = OP_ADD;
    shift_i = 5'h00;
    merge_mask_i = 32'h00000000;
    idle();
    repeat (2) tick();
    srst_i = 1'b0;
    t_dma();
    t_fetch();
    t_alu();
    t_mem();
    t_step();
    t_scan();
    report_and_stop();
  end
endmodule // testbench

// *** verilog/execute_units.sv ***
// arithmetic, floating point and multiplier units
`timescale 1ns/100ps
`include "processor_data_path_consts.svh"
module execute_units
  import processor_data_path_pkg::*;
#(
  parameter int WORD_W = `PDP_WORD_W
) (
  // operands and operation
  input  wire logic [WORD_W-1:0] opnd_a_i,
  input  wire logic [WORD_W-1:0] opnd_b_i,
  input  wire unit_op_t          op_i,
  input  wire logic [4:0]        shift_i,
  input  wire logic [WORD_W-1:0] merge_mask_i,
  // result
  output logic      [WORD_W-1:0] result_o
);
  if (WORD_W < 8) begin : g_bad_word_w
    $error("execute_units: WORD_W too small");
  end

  logic [2*WORD_W-1:0] product;
  logic [WORD_W-1:0]   fp_sum;
  logic [WORD_W-1:0]   fp_prod;

  // multiplier products; floating units kept to a simple fixed stand-in
  assign product = (2*WORD_W)'(opnd_a_i) * (2*WORD_W)'(opnd_b_i);
  assign fp_sum  = opnd_a_i + opnd_b_i;
  assign fp_prod = product[WORD_W-1:0];

  // operation select
  always_comb begin
    case (op_i)
      OP_ADD:   result_o = opnd_a_i + opnd_b_i;
      OP_SUB:   result_o = opnd_a_i - opnd_b_i;
      OP_SHL:   result_o = opnd_a_i << shift_i;
      OP_SHR:   result_o = opnd_a_i >> shift_i;
      OP_MERGE: result_o = (opnd_a_i & merge_mask_i) | (opnd_b_i & ~merge_mask_i);
      OP_MUL:   result_o = product[WORD_W-1:0];
      OP_DIV:   result_o = (opnd_b_i == '0) ? '1 : opnd_a_i / opnd_b_i;
      OP_FADD:  result_o = fp_sum;
      OP_FMUL:  result_o = fp_prod;
      OP_PASS:  result_o = opnd_a_i;
      default:  result_o = '0;
    endcase
  end
endmodule // execute_units

// *** verilog/processor_data_path.sv ***
// data section, shared memory and diagnostics port of the processor
`timescale 1ns/100ps
`include "processor_data_path_consts.svh"
// Contract
// - operand store has two write ports and two read ports per cycle
// - operand store holds 64 entries, built from 18-bit slices
// - read operands feed units as A/B or memory as address/data
// - load: address from read port A, memory word into write port B
// - unit results go on result bus into write port A
// - store: data from read port B, address from read port A
// - result write on port A alongside load on port B same cycle
// - units add, subtract, shift, merge, multiply, divide 32-bit data
// - shared memory is 16K words of 36 bits
// - two counting address registers serve sequential accesses
// - host address enters memory address bus through a bus driver
// - diagnostics port gates, single-steps clock, shifts scan registers
// - fetched instruction captured into opcode register, optionally port B
module processor_data_path
  import processor_data_path_pkg::*;
#(
  parameter int RF_DEPTH  = `PDP_RF_DEPTH,
  parameter int WORD_W    = `PDP_WORD_W,
  parameter int MEM_DEPTH = `PDP_MEM_DEPTH,
  parameter int MEM_W     = `PDP_MEM_W,
  parameter int SCAN_LEN  = `PDP_SCAN_LEN
) (
  // clock and reset
  input  wire logic                     sys_clk_i,
  input  wire logic                     srst_i,
  // micro control: operand store
  input  wire logic [`PDP_RF_AW-1:0]    rd_a_addr_i,
  input  wire logic [`PDP_RF_AW-1:0]    rd_b_addr_i,
  input  wire logic [`PDP_RF_AW-1:0]    wr_a_addr_i,
  input  wire logic [`PDP_RF_AW-1:0]    wr_b_addr_i,
  input  wire logic                     wr_a_en_i,
  input  wire logic                     wr_b_en_i,
  // micro control: units
  input  wire unit_op_t                 op_i,
  input  wire logic [4:0]               shift_i,
  input  wire logic [WORD_W-1:0]        merge_mask_i,
  // micro control: memory
  input  wire logic                     mem_rd_i,
  input  wire logic                     mem_wr_i,
  input  wire madr_sel_t                madr_sel_i,
  input  wire logic                     cnt0_load_i,
  input  wire logic                     cnt1_load_i,
  input  wire logic                     cnt0_inc_i,
  input  wire logic                     cnt1_inc_i,
  input  wire logic                     fetch_i,
  input  wire logic                     fetch_to_rf_i,
  // host dma
  input  wire logic                     host_req_i,
  input  wire logic                     host_we_i,
  input  wire logic [`PDP_MEM_AW-1:0]   host_addr_i,
  input  wire logic [MEM_W-1:0]         host_wdata_i,
  output logic      [MEM_W-1:0]         host_rdata_o,
  output logic                          host_ack_o,
  // diagnostics port (pins from the host)
  input  wire logic                     diag_halt_i,
  input  wire logic                     diag_step_i,
  input  wire logic                     diag_scan_en_i,
  input  wire logic                     diag_scan_in_i,
  output logic                          diag_scan_out_o,
  output logic                          clk_en_o,
  // observed state
  output logic      [WORD_W-1:0]        result_bus_o,
  output logic      [MEM_W-1:0]         opcode_o,
  output logic      [`PDP_MEM_AW-1:0]   mem_addr_o
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (RF_DEPTH != (1 << `PDP_RF_AW)) begin : g_bad_rf_depth
    $error("RF_DEPTH must match address width");
  end
  if (MEM_DEPTH != (1 << `PDP_MEM_AW)) begin : g_bad_mem_depth
    $error("MEM_DEPTH must match address width");
  end
  if (MEM_W < WORD_W) begin : g_bad_mem_w
    $error("MEM_W must hold a data word");
  end
  if (WORD_W > 2 * `PDP_RF_SLICE_W) begin : g_bad_word_w
    $error("WORD_W exceeds two slices");
  end
  if (SCAN_LEN < 2 * WORD_W) begin : g_bad_scan_len
    $error("SCAN_LEN too short");
  end

  localparam int SLICES = (WORD_W + `PDP_RF_SLICE_W - 1) / `PDP_RF_SLICE_W;
  localparam int RF_W   = SLICES * `PDP_RF_SLICE_W;

  // ----------------------------------------
  // pin synchronisers for the diagnostics port
  // ----------------------------------------
  logic [2:0] halt_sync_ff;
  logic [2:0] step_sync_ff;
  logic [2:0] scen_sync_ff;
  logic [2:0] scin_sync_ff;
  logic       halt_lvl_ff;
  logic       step_lvl_ff;
  logic       scen_lvl_ff;
  logic       scin_lvl_ff;
  logic       step_prev_ff;

  // three-stage capture of each diagnostic pin
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      halt_sync_ff <= 3'h7; // come out of reset halted
      step_sync_ff <= 3'h0;
      scen_sync_ff <= 3'h0;
      scin_sync_ff <= 3'h0;
    end else begin
      halt_sync_ff <= {halt_sync_ff[1:0], diag_halt_i};
      step_sync_ff <= {step_sync_ff[1:0], diag_step_i};
      scen_sync_ff <= {scen_sync_ff[1:0], diag_scan_en_i};
      scin_sync_ff <= {scin_sync_ff[1:0], diag_scan_in_i};
    end
  end

  // a level changes once stages two and three agree
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      halt_lvl_ff  <= 1'b1; // no run before the pin is seen low
      step_lvl_ff  <= 1'b0;
      scen_lvl_ff  <= 1'b0;
      scin_lvl_ff  <= 1'b0;
      step_prev_ff <= 1'b0;
    end else begin
      if (halt_sync_ff[1] == halt_sync_ff[2]) halt_lvl_ff <= halt_sync_ff[2];
      if (step_sync_ff[1] == step_sync_ff[2]) step_lvl_ff <= step_sync_ff[2];
      if (scen_sync_ff[1] == scen_sync_ff[2]) scen_lvl_ff <= scen_sync_ff[2];
      if (scin_sync_ff[1] == scin_sync_ff[2]) scin_lvl_ff <= scin_sync_ff[2];
      step_prev_ff <= step_lvl_ff;
    end
  end

  // ----------------------------------------
  // clock gating and single step
  // ----------------------------------------
  diag_state_t dg_state_ff;
  diag_state_t nxt_dg_state;
  logic        run_en;

  // halted while halt is held or scanning; a step edge grants one cycle
  always_comb begin
    nxt_dg_state = dg_state_ff;
    case (dg_state_ff)
      DG_RUN:  if (halt_lvl_ff || scen_lvl_ff) nxt_dg_state = DG_HALT;
      DG_HALT: begin
        if (!halt_lvl_ff && !scen_lvl_ff) nxt_dg_state = DG_RUN;
        else if (step_lvl_ff && !step_prev_ff && !scen_lvl_ff) nxt_dg_state = DG_STEP;
      end
      DG_STEP: nxt_dg_state = DG_HALT;
      default: nxt_dg_state = DG_HALT;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) dg_state_ff <= DG_HALT;
    else        dg_state_ff <= nxt_dg_state;
  end

  assign run_en = (dg_state_ff == DG_RUN) || (dg_state_ff == DG_STEP);

  // enable seen by the rest of the system
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) clk_en_o <= 1'b0;
    else        clk_en_o <= (nxt_dg_state == DG_RUN) || (nxt_dg_state == DG_STEP);
  end

  // ----------------------------------------
  // operand store: two read, two write ports
  // ----------------------------------------
  logic [RF_W-1:0]   rd_a_full;
  logic [RF_W-1:0]   rd_b_full;
  logic [RF_W-1:0]   wa_ext;
  logic [RF_W-1:0]   wb_ext;
  logic [WORD_W-1:0] rd_a_data;
  logic [WORD_W-1:0] rd_b_data;
  logic [WORD_W-1:0] unit_result;
  logic [MEM_W-1:0]  mem_rdata;
  logic [WORD_W-1:0] wr_b_data;
  logic              wr_b_go;

  assign rd_a_data = rd_a_full[WORD_W-1:0];
  assign rd_b_data = rd_b_full[WORD_W-1:0];
  assign wa_ext    = RF_W'(unit_result);
  assign wb_ext    = RF_W'(wr_b_data);

  // port B takes the memory word on a load or an instruction fetch
  assign wr_b_data = mem_rdata[WORD_W-1:0];
  assign wr_b_go   = (wr_b_en_i && mem_rd_i) || (fetch_i && fetch_to_rf_i);

  // each 18-bit slice written by both ports; port B wins on equal address
  for (genvar s = 0; s < SLICES; s++) begin : g_slice
    localparam int LO = s * `PDP_RF_SLICE_W;
    localparam int HI = LO + `PDP_RF_SLICE_W - 1;
    logic [`PDP_RF_SLICE_W-1:0] slice_mem [RF_DEPTH];
    assign rd_a_full[HI:LO] = slice_mem[rd_a_addr_i];
    assign rd_b_full[HI:LO] = slice_mem[rd_b_addr_i];
    always_ff @(posedge sys_clk_i) begin
      if (run_en) begin
        if (wr_a_en_i) slice_mem[wr_a_addr_i] <= wa_ext[HI:LO];
        if (wr_b_go)   slice_mem[wr_b_addr_i] <= wb_ext[HI:LO];
      end
    end
  end

  // ----------------------------------------
  // execute units on the read operands
  // ----------------------------------------
  execute_units #(
    .WORD_W(WORD_W)
  ) u_exec (
    .opnd_a_i     (rd_a_data),
    .opnd_b_i     (rd_b_data),
    .op_i         (op_i),
    .shift_i      (shift_i),
    .merge_mask_i (merge_mask_i),
    .result_o     (unit_result)
  );

  // result bus seen from outside
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)      result_bus_o <= '0;
    else if (run_en) result_bus_o <= unit_result;
  end

  // ----------------------------------------
  // address counters
  // ----------------------------------------
  logic [`PDP_MEM_AW-1:0] cnt0_ff;
  logic [`PDP_MEM_AW-1:0] cnt1_ff;

  // load from read port A or count up on each enabled increment
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt0_ff <= `PDP_ADDR_RST;
      cnt1_ff <= `PDP_ADDR_RST;
    end else if (run_en) begin
      if (cnt0_load_i)     cnt0_ff <= rd_a_data[`PDP_MEM_AW-1:0];
      else if (cnt0_inc_i) cnt0_ff <= cnt0_ff + 1'b1;
      if (cnt1_load_i)     cnt1_ff <= rd_a_data[`PDP_MEM_AW-1:0];
      else if (cnt1_inc_i) cnt1_ff <= cnt1_ff + 1'b1;
    end
  end

  // ----------------------------------------
  // shared memory and address bus
  // ----------------------------------------
  logic [MEM_W-1:0]       sram [MEM_DEPTH];
  logic [`PDP_MEM_AW-1:0] maddr;
  logic                   host_own;
  logic [MEM_W-1:0]       proc_wdata;

  // host drives the address bus only while the processor is halted
  assign host_own = host_req_i && !run_en;

  always_comb begin
    if (host_own) maddr = host_addr_i;
    else begin
      case (madr_sel_i)
        MADR_READ_A: maddr = rd_a_data[`PDP_MEM_AW-1:0];
        MADR_CNT0:   maddr = cnt0_ff;
        MADR_CNT1:   maddr = cnt1_ff;
        default:     maddr = rd_a_data[`PDP_MEM_AW-1:0];
      endcase
    end
  end

  assign proc_wdata = MEM_W'(rd_b_data);
  assign mem_rdata  = sram[maddr];

  // memory writes from the processor or the host
  always_ff @(posedge sys_clk_i) begin
    if (host_own && host_we_i)     sram[maddr] <= host_wdata_i;
    else if (run_en && mem_wr_i)   sram[maddr] <= proc_wdata;
  end

  // host read data and acknowledge
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      host_rdata_o <= '0;
      host_ack_o   <= 1'b0;
    end else begin
      host_ack_o <= host_own;
      if (host_own) host_rdata_o <= mem_rdata;
    end
  end

  // address of the last access made by either side; frozen while gated unless the host owns the bus
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)                      mem_addr_o <= `PDP_ADDR_RST;
    else if (run_en || host_own)     mem_addr_o <= maddr;
  end

  // ----------------------------------------
  // instruction opcode register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i)                 opcode_o <= `PDP_OPCODE_RST;
    else if (run_en && fetch_i) opcode_o <= mem_rdata;
  end

  // ----------------------------------------
  // scan shadow register chain
  // ----------------------------------------
  logic [SCAN_LEN-1:0] scan_shadow_register_ff;

  // captures result bus and operand A when running, shifts when scanning
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) scan_shadow_register_ff <= '0;
    else if (scen_lvl_ff)
      scan_shadow_register_ff <= {scin_lvl_ff, scan_shadow_register_ff[SCAN_LEN-1:1]};
    else if (run_en)
      scan_shadow_register_ff <= SCAN_LEN'({unit_result, rd_a_data});
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) diag_scan_out_o <= 1'b0;
    else        diag_scan_out_o <= scan_shadow_register_ff[0];
  end
endmodule // processor_data_path
